// file: chk_consts.vh
// Constants for the block check character generator and character counter
//
// Summary of operation
// - Block text entry clears horizontal check flops
// - Mark toggles horizontal flop, space leaves it
// - Horizontal flops hold per-level mark parity
// - Block text entry also clears spiral flops
// - Second-gated mark sets spiral flop, space holds
// - Spiral shift 200 us after read-in
// - Shift rotates spiral register, level 8 to 1
// - Spiral contents after 80th character form check
// - Count feeds, punch commands, or gated clocks
// - Count 80 advances to next programmer mode
// - Ten-state units ring, nine-state tens ring
// - Block text or delete entry clears rings
// - Punch back-up signal also clears rings
// - Source: punch sample, gated clock, or feed
// - Units step on falling edge of source
// - Units wrap after nine, stepping tens ring
// - Levels gated only in block text or end-of-block
// - Spiral levels blocked during first check mode
// - Tens seventy to eighty advances, to delete when backing up
`ifndef CHK_CONSTS_VH
`define CHK_CONSTS_VH

// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_HCHK        8'h04
`define OFS_SCHK        8'h08
`define OFS_COUNT       8'h0C
`define OFS_STATUS      8'h10

// Control register fields and reset value
`define CTRL_GEN_EN     0
`define CTRL_SOFT_CLR   1
`define CTRL_RESET      2'h1

// Count register fields
`define COUNT_UNITS_LSB 0
`define COUNT_TENS_LSB  8

// Timing
`define CLK_PERIOD_NS   100
`define SET_WINDOW_NS   200000
`define SET_WINDOW_CYC  (`SET_WINDOW_NS / `CLK_PERIOD_NS)

// Ring sizes and the tens state that ends a block
`define UNITS_STATES    10
`define TENS_STATES     9
`define TENS_BLOCK_END  8

`endif

// file: check_char_regs.v
// Horizontal parity and spiral check character registers
`timescale 1ns/1ps
module check_char_regs #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             sys_clk,
    input  wire             srst,
    // Strobes
    input  wire             clear_stb,
    input  wire             read_in_stb,
    input  wire             shift_stb,
    // Gated levels
    input  wire [WIDTH-1:0] first_levels,
    input  wire [WIDTH-1:0] second_levels,
    // Check characters
    output reg  [WIDTH-1:0] horiz_r,
    output reg  [WIDTH-1:0] spiral_r
);

    always @(posedge sys_clk) begin
        if (srst || clear_stb) begin
            horiz_r  <= {WIDTH{1'b0}};
            spiral_r <= {WIDTH{1'b0}};
        end else begin
            if (read_in_stb)
                horiz_r <= horiz_r ^ first_levels;
            // If read-in and shift share a cycle, the set wins and the shift is lost
            if (read_in_stb)
                spiral_r <= spiral_r | second_levels;
            else if (shift_stb)
                spiral_r <= {spiral_r[WIDTH-2:0], spiral_r[WIDTH-1]};
        end
    end

endmodule

// file: char_ring_counter.v
// Units and tens ring character counter
`timescale 1ns/1ps
`include "chk_consts.vh"
module char_ring_counter #(
    parameter UNITS = `UNITS_STATES,
    parameter TENS  = `TENS_STATES
) (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       srst,
    // Control strobes
    input  wire       clear_stb,
    input  wire       count_stb,
    // Ring states and seventy-to-eighty tens step indication
    output reg  [3:0] units_r,
    output reg  [3:0] tens_r,
    output reg        reach_end_r
);

    localparam integer UNITS_LAST_I = UNITS - 1;
    localparam integer TENS_LAST_I  = TENS - 1;
    localparam integer TENS_END_I   = `TENS_BLOCK_END;
    localparam [3:0]   UNITS_LAST   = UNITS_LAST_I[3:0];
    localparam [3:0]   TENS_LAST    = TENS_LAST_I[3:0];
    localparam [3:0]   TENS_END     = TENS_END_I[3:0];

    always @(posedge sys_clk) begin
        if (srst || clear_stb) begin
            units_r     <= 4'h0;
            tens_r      <= 4'h0;
            reach_end_r <= 1'b0;
        end else begin
            reach_end_r <= 1'b0;
            if (count_stb) begin
                if (units_r == UNITS_LAST) begin
                    units_r <= 4'h0;
                    tens_r  <= (tens_r == TENS_LAST) ? 4'h0 : tens_r + 4'h1;
                    // Seventy to eighty marks a full block
                    reach_end_r <= (tens_r + 4'h1 == TENS_END);
                end else begin
                    units_r <= units_r + 4'h1;
                end
            end
        end
    end

endmodule

// file: block_check_counter.v
// Block check character generator and character counter with AHB-Lite registers
//
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "chk_consts.vh"
module block_check_counter #(
    parameter WIDTH      = 8,
    parameter WINDOW_CYC = `SET_WINDOW_CYC
) (
    // Clock and reset
    input  wire             sys_clk,
    input  wire             srst,
    // AHB-Lite slave
    input  wire             hsel,
    input  wire [31:0]      haddr,
    input  wire [1:0]       htrans,
    input  wire             hwrite,
    input  wire [2:0]       hsize,
    input  wire             hready,
    input  wire [31:0]      hwdata,
    output wire             hreadyout,
    output wire             hresp,
    output reg  [31:0]      hrdata,
    // Programmer modes
    input  wire             block_text_mode,
    input  wire             end_of_block_mode,
    input  wire             delete_mode,
    input  wire             backup_mode,
    input  wire             first_check_char,
    input  wire             block_number_low,
    // Reader and punch
    input  wire [WIDTH-1:0] char_levels,
    input  wire             feed_pulse,
    input  wire             gated_clock,
    input  wire             punch_sample_n,
    // Check characters
    output wire [WIDTH-1:0] horiz_check,
    output wire [WIDTH-1:0] spiral_check,
    // Programmer advance strobes
    output reg              adv_to_eob_r,
    output reg              adv_to_delete_r,
    output reg              adv_to_sync_idle_r
);

    localparam integer WIN_LAST_I = WINDOW_CYC - 1;
    localparam [15:0]  WIN_LAST   = WIN_LAST_I[15:0];

    // Window state machine
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_WIN  = 2'b10;

    function rise;
        input cur;
        input prev;
        begin
            rise = cur & ~prev;
        end
    endfunction

    // Edge detect history
    reg              bk_d_r;
    reg              del_d_r;
    reg              bu_d_r;
    reg              feed_d_r;
    reg              src_d_r;

    // Register state
    reg  [1:0]       ctrl_r;
    reg              soft_clr_r;
    reg  [1:0]       state_r;
    reg  [1:0]       state_nxt;
    reg  [15:0]      win_cnt_r;
    reg              shift_r;

    // AHB address phase capture
    reg              wr_pend_r;
    reg  [7:0]       wr_addr_r;

    wire             gen_en       = ctrl_r[`CTRL_GEN_EN];
    wire             gate_open    = block_text_mode | end_of_block_mode;
    wire             clear_stb    = rise(block_text_mode, bk_d_r) | soft_clr_r;
    wire             read_in_stb  = rise(feed_pulse, feed_d_r) & gate_open & gen_en;
    wire [WIDTH-1:0] first_lv     = char_levels & {WIDTH{read_in_stb}};
    wire [WIDTH-1:0] second_lv    = first_lv & {WIDTH{~first_check_char}};

    // Count source; the feed pulse is taken inverted
    wire             count_src    = delete_mode ? punch_sample_n :
                                    (block_number_low ? gated_clock : ~feed_pulse);
    wire             count_stb    = src_d_r & ~count_src;
    wire             cnt_clear    = rise(block_text_mode, bk_d_r) | rise(delete_mode, del_d_r)
                                    | rise(backup_mode, bu_d_r);

    wire [3:0]       units;
    wire [3:0]       tens;
    wire             reach_end;

    wire             addr_phase   = hsel & htrans[1] & hready;

    always @(posedge sys_clk) begin
        if (srst) begin
            bk_d_r   <= 1'b0;
            del_d_r  <= 1'b0;
            bu_d_r   <= 1'b0;
            feed_d_r <= 1'b0;
            src_d_r  <= 1'b0;
        end else begin
            bk_d_r   <= block_text_mode;
            del_d_r  <= delete_mode;
            bu_d_r   <= backup_mode;
            feed_d_r <= feed_pulse;
            src_d_r  <= count_src;
        end
    end

    // Character set window: a new read-in restarts it
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (read_in_stb)
                    state_nxt = ST_WIN;
            end
            ST_WIN: begin
                if (clear_stb)
                    state_nxt = ST_IDLE;
                else if (!read_in_stb && win_cnt_r == WIN_LAST)
                    state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            state_r   <= ST_IDLE;
            win_cnt_r <= 16'h0000;
            shift_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            shift_r <= 1'b0;
            if (read_in_stb) begin
                win_cnt_r <= 16'h0000;
            end else if (state_r == ST_WIN) begin
                win_cnt_r <= win_cnt_r + 16'h0001;
                // Trailing edge of the set window fires one shift
                if (win_cnt_r == WIN_LAST && !clear_stb)
                    shift_r <= 1'b1;
            end
        end
    end

    check_char_regs #(
        .WIDTH (WIDTH)
    ) u_regs (
        .sys_clk       (sys_clk),
        .srst          (srst),
        .clear_stb     (clear_stb),
        .read_in_stb   (read_in_stb),
        .shift_stb     (shift_r),
        .first_levels  (first_lv),
        .second_levels (second_lv),
        .horiz_r       (horiz_check),
        .spiral_r      (spiral_check)
    );

    char_ring_counter #(
        .UNITS (`UNITS_STATES),
        .TENS  (`TENS_STATES)
    ) u_count (
        .sys_clk     (sys_clk),
        .srst        (srst),
        .clear_stb   (cnt_clear),
        .count_stb   (count_stb),
        .units_r     (units),
        .tens_r      (tens),
        .reach_end_r (reach_end)
    );

    // Mode advance on reaching eighty
    always @(posedge sys_clk) begin
        if (srst) begin
            adv_to_eob_r       <= 1'b0;
            adv_to_delete_r    <= 1'b0;
            adv_to_sync_idle_r <= 1'b0;
        end else begin
            adv_to_eob_r       <= reach_end & ~backup_mode & ~delete_mode;
            adv_to_delete_r    <= reach_end & backup_mode;
            adv_to_sync_idle_r <= reach_end & delete_mode & ~backup_mode;
        end
    end

    // AHB-Lite slave: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always @(posedge sys_clk) begin
        if (srst) begin
            wr_pend_r  <= 1'b0;
            wr_addr_r  <= 8'h00;
            ctrl_r     <= `CTRL_RESET;
            soft_clr_r <= 1'b0;
            hrdata     <= 32'h0000_0000;
        end else begin
            soft_clr_r <= 1'b0;
            if (hready) begin
                wr_pend_r <= addr_phase & hwrite;
                wr_addr_r <= haddr[7:0];
            end
            if (wr_pend_r && wr_addr_r == `OFS_CTRL) begin
                ctrl_r[`CTRL_GEN_EN] <= hwdata[`CTRL_GEN_EN];
                // Self-clearing; reads back as zero
                soft_clr_r <= hwdata[`CTRL_SOFT_CLR];
            end
            // Read data captured in address phase, valid through data phase
            if (addr_phase && !hwrite) begin
                case (haddr[7:0])
                    `OFS_CTRL:   hrdata <= {30'h0, 1'b0, ctrl_r[`CTRL_GEN_EN]};
                    `OFS_HCHK:   hrdata <= {{(32-WIDTH){1'b0}}, horiz_check};
                    `OFS_SCHK:   hrdata <= {{(32-WIDTH){1'b0}}, spiral_check};
                    `OFS_COUNT:  hrdata <= {20'h0, tens, 4'h0, units};
                    `OFS_STATUS: hrdata <= {24'h0, state_r == ST_WIN, block_number_low,
                                            first_check_char, backup_mode, delete_mode,
                                            end_of_block_mode, block_text_mode, gate_open};
                    default:     hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

// file: block_check_counter_chk.sv
// Port-level assertions for the block check and character counter
`timescale 1ns/1ps
module block_check_counter_chk #(
    parameter int WIDTH      = 8,
    parameter int WINDOW_CYC = 8
) (
    // Clock and reset
    input wire             sys_clk,
    input wire             srst,
    // Modes and reader
    input wire             block_text_mode,
    input wire             end_of_block_mode,
    input wire             delete_mode,
    input wire             backup_mode,
    input wire             first_check_char,
    input wire             feed_pulse,
    input wire [WIDTH-1:0] char_levels,
    // Results
    input wire [WIDTH-1:0] horiz_check,
    input wire [WIDTH-1:0] spiral_check,
    input wire             adv_to_eob_r,
    input wire             adv_to_delete_r,
    input wire             adv_to_sync_idle_r
);
    // Rotate shows a window plus two edges after the sampled feed rise
    localparam int ROT_DLY = WINDOW_CYC + 2;
    wire gate_open = block_text_mode | end_of_block_mode;
    wire any_adv   = adv_to_eob_r | adv_to_delete_r | adv_to_sync_idle_r;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);

    property p_tog;
        ($rose(feed_pulse) && gate_open)
            |=> horiz_check == ($past(horiz_check) ^ $past(char_levels));
    endproperty
    property p_set;
        ($rose(feed_pulse) && gate_open) |=> spiral_check == ($past(spiral_check)
            | ($past(first_check_char) ? {WIDTH{1'b0}} : $past(char_levels)));
    endproperty
    property p_rot;
        ($rose(feed_pulse) && gate_open) |-> ##ROT_DLY
            spiral_check == {$past(spiral_check[WIDTH-2:0]), $past(spiral_check[WIDTH-1])};
    endproperty

    AST_CLEAR: assert property ($rose(block_text_mode) |-> ##[1:3]
        (horiz_check == '0 && spiral_check == '0)) else $error("check clear missing");
    AST_TOGGLE: assert property (p_tog) else $error("horizontal toggle wrong");
    AST_SET: assert property (p_set) else $error("spiral set wrong");
    AST_ROTATE: assert property (p_rot) else $error("spiral rotate wrong");
    AST_HOLD: assert property (!$stable(horiz_check) |->
        $past(feed_pulse) || horiz_check == '0) else $error("horizontal changed idle");
    AST_ADV_EOB: assert property (adv_to_eob_r |-> !backup_mode && !delete_mode)
        else $error("end of block advance in wrong mode");
    AST_ADV_SI: assert property (adv_to_sync_idle_r |-> delete_mode && !backup_mode)
        else $error("sync idle advance in wrong mode");
    AST_ADV_DEL: assert property (adv_to_delete_r |-> backup_mode)
        else $error("delete advance in wrong mode");
    AST_PULSE: assert property (any_adv |=> !any_adv)
        else $error("advance longer than one cycle");

    cover property (adv_to_eob_r);
    cover property (adv_to_sync_idle_r);
    cover property (adv_to_delete_r);
endmodule

bind block_check_counter block_check_counter_chk #(.WIDTH(WIDTH), .WINDOW_CYC(WINDOW_CYC)) chk (
    .sys_clk, .srst, .block_text_mode, .end_of_block_mode, .delete_mode, .backup_mode,
    .first_check_char, .feed_pulse, .char_levels, .horiz_check, .spiral_check,
    .adv_to_eob_r, .adv_to_delete_r, .adv_to_sync_idle_r
);

// file: reader_model.sv
// Photo reader model: two-cycle feed pulse framing the character levels
`timescale 1ns/1ps
module reader_model (
    // Clock and command
    input  wire        sys_clk,
    input  wire        go,
    input  wire  [7:0] ch,
    // Reader outputs
    output logic       feed_pulse,
    output logic [7:0] char_levels
);
    logic [1:0] cnt_r;
    initial begin
        feed_pulse = 1'b0;
        char_levels = 8'h00;
        cnt_r = 2'h0;
    end
    always @(posedge sys_clk) begin
        if (go) begin
            feed_pulse  <= 1'b1;
            char_levels <= ch;
            cnt_r       <= 2'h2;
        end else if (cnt_r == 2'h1) begin
            feed_pulse  <= 1'b0;
            // Released levels must not look like the last character
            char_levels <= ~char_levels;
            cnt_r       <= 2'h0;
        end else if (cnt_r != 2'h0) begin
            cnt_r <= cnt_r - 2'h1;
        end
    end
endmodule

// file: block_check_counter_bench.sv
// Self-checking bench for the block check and character counter
`timescale 1ns/1ps
`include "chk_consts.vh"
module block_check_counter_bench;
    localparam int WIN = 8;
    logic        sys_clk, srst, hsel, hwrite, go, gated_clock, punch_sample_n;
    logic        block_text_mode, end_of_block_mode, delete_mode, backup_mode;
    logic        first_check_char, block_number_low;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0]  htrans;
    logic [7:0]  ch, h_exp, s_exp, char_levels, horiz_check, spiral_check;
    logic        feed_pulse, hreadyout, hresp, adv_to_eob_r, adv_to_delete_r;
    logic        adv_to_sync_idle_r;
    logic [31:0] hrdata;
    int          miscompares, n_checks, n_eob, n_del, n_si;

    block_check_counter #(.WINDOW_CYC(WIN)) DUT (
        .sys_clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout),
        .hwdata, .hreadyout, .hresp, .hrdata, .block_text_mode, .end_of_block_mode,
        .delete_mode, .backup_mode, .first_check_char, .block_number_low, .char_levels,
        .feed_pulse, .gated_clock, .punch_sample_n, .horiz_check, .spiral_check,
        .adv_to_eob_r, .adv_to_delete_r, .adv_to_sync_idle_r
    );
    reader_model rdr (.sys_clk, .go, .ch, .feed_pulse, .char_levels);

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        n_eob <= n_eob + int'(adv_to_eob_r === 1'b1);
        n_del <= n_del + int'(adv_to_delete_r === 1'b1);
        n_si  <= n_si + int'(adv_to_sync_idle_r === 1'b1);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h000000, a};
        do @(posedge sys_clk); while (hreadyout !== 1'b1 && ++t < 50);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1 && ++t < 50);
        if (t >= 50) miscompares++;
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        check(rd, exp);
    endtask
    task automatic feed_char(input logic [7:0] c);
        go <= 1'b1;
        ch <= c;
        @(posedge sys_clk);
        go <= 1'b0;
        repeat (WIN + 6) @(posedge sys_clk);
    endtask
    function automatic logic [7:0] rot(input logic [7:0] v);
        return {v[6:0], v[7]};
    endfunction

    task automatic sc_block();
        logic [7:0] c;
        int e0;
        e0 = n_eob;
        h_exp = 8'h00;
        s_exp = 8'h00;
        block_text_mode <= 1'b1;
        repeat (4) @(posedge sys_clk);
        for (int i = 0; i < 80; i++) begin
            c = 8'(i * 8'h1D + 8'h03);
            h_exp = h_exp ^ c;
            s_exp = rot(s_exp | c);
            feed_char(c);
        end
        check(32'(horiz_check), 32'(h_exp));
        check(32'(spiral_check), 32'(s_exp));
        rdchk(`OFS_HCHK, 32'(h_exp));
        rdchk(`OFS_SCHK, 32'(s_exp));
        rdchk(`OFS_COUNT, 32'h00000800);
        check(32'(n_eob - e0), 32'h1);
    endtask
    task automatic sc_first();
        block_text_mode   <= 1'b0;
        end_of_block_mode <= 1'b1;
        first_check_char  <= 1'b1;
        feed_char(8'hA5);
        check(32'(horiz_check), 32'(h_exp ^ 8'hA5));
        check(32'(spiral_check), 32'(rot(s_exp)));
        bus(1'b1, `OFS_CTRL, 32'h00000003);
        repeat (2) @(posedge sys_clk);
        check(32'({horiz_check, spiral_check}), 32'h0);
        rdchk(`OFS_STATUS, 32'h00000025);
        rdchk(`OFS_COUNT, 32'h00000801);
        end_of_block_mode <= 1'b0;
        first_check_char  <= 1'b0;
        block_text_mode   <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check(32'({horiz_check, spiral_check}), 32'h0);
        rdchk(`OFS_COUNT, 32'h00000000);
    endtask
    task automatic sc_gclk();
        int e0;
        e0 = n_eob;
        block_number_low <= 1'b1;
        for (int i = 0; i < 80; i++) begin
            gated_clock <= 1'b0;
            @(posedge sys_clk);
            gated_clock <= 1'b1;
            @(posedge sys_clk);
            if (i == 14) rdchk(`OFS_COUNT, 32'h00000105);
        end
        repeat (3) @(posedge sys_clk);
        check(32'(n_eob - e0), 32'h1);
    endtask
    task automatic sc_delete();
        int e0;
        e0 = n_si;
        block_number_low <= 1'b0;
        block_text_mode  <= 1'b0;
        delete_mode      <= 1'b1;
        repeat (3) @(posedge sys_clk);
        repeat (80) begin
            punch_sample_n <= 1'b0;
            @(posedge sys_clk);
            punch_sample_n <= 1'b1;
            @(posedge sys_clk);
        end
        repeat (3) @(posedge sys_clk);
        check(32'(n_si - e0), 32'h1);
        rdchk(`OFS_COUNT, 32'h00000800);
    endtask
    task automatic sc_backup();
        int e0;
        e0 = n_del;
        delete_mode <= 1'b0;
        backup_mode <= 1'b1;
        repeat (3) @(posedge sys_clk);
        repeat (80) feed_char(8'hFF);
        check(32'(n_del - e0), 32'h1);
        check(32'(horiz_check), 32'h0);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #2_000_000;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        {srst, hsel, hwrite, go, ch, haddr, hwdata, htrans} = '0;
        srst = 1'b1;
        {block_text_mode, end_of_block_mode, delete_mode, backup_mode} = 4'h0;
        {first_check_char, block_number_low} = 2'h0;
        {gated_clock, punch_sample_n} = 2'h3;
        {miscompares, n_checks, n_eob, n_del, n_si} = '0;
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        rdchk(`OFS_CTRL, 32'h00000001);
        check(32'(hresp), 32'h0);
        rdchk(8'h20, 32'h00000000);
        bus(1'b1, `OFS_CTRL, 32'h00000003);
        rdchk(`OFS_CTRL, 32'h00000001);
        sc_block();
        sc_first();
        sc_gclk();
        sc_delete();
        sc_backup();
        tally_and_finish();
    end
endmodule
